// [rtl/afcb_bank.sv]
// file: top of the filter coefficient bank, ten byte registers
// assumes: single clock, master strobes one cycle wide, never both at once
//
// What this block does
// RL1 - each coefficient is its upper byte joined to its lower byte into one signed 16-bit word.
// RL2 - every 16-bit code from -32768 to 32767 is accepted as a coefficient.
// RL3 - the registers at offsets 25 to 34 are eight bits wide and fully read/write.
// RL4 - after reset the de-emphasis denominator tap one holds upper 0x53 and lower 0x7E.
// RL5 - after reset numerator tap zero holds upper 0x6B and lower 0xE3.
// RL6 - after reset numerator tap one holds upper 0x96 and lower 0x66.
// RL7 - after reset the upper byte of numerator tap two holds 0x67.
// RL8 - after reset the upper byte of numerator tap three holds 0x6B.
// RL9 - a read returns the last byte written or the reset value, with no side effect.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module afcb_bank #(
  parameter int NUM_REGS = afcb_pkg::AFCB_NUM_REGS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output afcb_pkg::afcb_coefs_s coefs_q
);
  import afcb_pkg::*;

  localparam logic [7:0] RST_TABLE [NUM_REGS] = '{
    AFCB_RST_DEN1_UPPER, AFCB_RST_DEN1_LOWER,
    AFCB_RST_NUM0_UPPER, AFCB_RST_NUM0_LOWER,
    AFCB_RST_NUM1_UPPER, AFCB_RST_NUM1_LOWER,
    AFCB_RST_NUM2_UPPER, AFCB_RST_NUM2_LOWER,
    AFCB_RST_NUM3_UPPER, AFCB_RST_NUM3_LOWER
  };

  // the map is fixed: ten bytes, paired into five words
  generate
    if (NUM_REGS != AFCB_NUM_REGS || NUM_REGS % 2 != 0) begin : g_bad_count
      $error("afcb_bank: register count must match the map");
    end
  endgenerate

  afcb_req_s req;
  logic [7:0] regs [NUM_REGS];
  logic [7:0] idx;
  logic in_map;
  logic [7:0] rd_mux;
  logic [8*NUM_REGS-1:0] regs_flat;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign in_map = (req.addr >= AFCB_FIRST_OFFSET) &&
                  (req.addr <= AFCB_LAST_OFFSET);
  assign idx = req.addr - AFCB_FIRST_OFFSET;

  // one register per offset, reset value from the table
  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      afcb_byte_reg #(
        .RESET_VALUE(RST_TABLE[g])
      ) u_reg (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(req.wr && in_map && (idx == 8'(g))),
        .wdata(req.wdata),
        .value_q(regs[g])
      );
      assign regs_flat[8*g +: 8] = regs[g];

      a_reg_write_lands: assert property ( // RL3
        @(posedge clk) disable iff (!rst_b)
        (reg_wr && in_map && idx == 8'(g)) |=>
          regs[g] == $past(reg_wdata))
        else $error("write did not land in its register");

      a_reg_readback: assert property ( // RL9
        @(posedge clk) disable iff (!rst_b)
        (reg_rd && in_map && idx == 8'(g)) |=>
          reg_rdata_q == $past(regs[g]))
        else $error("read data not the register value");
    end
  endgenerate

  always_comb begin
    rd_mux = AFCB_UNMAPPED_DATA;
    if (in_map) begin
      rd_mux = regs[idx[3:0]]; // RL9
    end
  end

  // read data stands one cycle after the strobe, else zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else if (req.rd) begin
      reg_rdata_q <= rd_mux; // RL9
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // signed words for the filter, registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coefs_q.den1 <= {AFCB_RST_DEN1_UPPER, AFCB_RST_DEN1_LOWER}; // RL4
      coefs_q.num0 <= {AFCB_RST_NUM0_UPPER, AFCB_RST_NUM0_LOWER}; // RL5
      coefs_q.num1 <= {AFCB_RST_NUM1_UPPER, AFCB_RST_NUM1_LOWER}; // RL6
      coefs_q.num2 <= {AFCB_RST_NUM2_UPPER, AFCB_RST_NUM2_LOWER}; // RL7
      coefs_q.num3 <= {AFCB_RST_NUM3_UPPER, AFCB_RST_NUM3_LOWER}; // RL8
    end else begin
      // full 16-bit span passes unclipped
      coefs_q.den1 <= signed'({regs[0], regs[1]}); // RL1 RL2
      coefs_q.num0 <= signed'({regs[2], regs[3]}); // RL1
      coefs_q.num1 <= signed'({regs[4], regs[5]}); // RL1
      coefs_q.num2 <= signed'({regs[6], regs[7]}); // RL1
      coefs_q.num3 <= signed'({regs[8], regs[9]}); // RL1
    end
  end

  // checks
  logic past_valid_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      past_valid_q <= 1'b0;
    end else begin
      past_valid_q <= 1'b1;
    end
  end

  sequence s_write_den1;
    reg_wr && reg_addr == AFCB_OFS_DEN1_UPPER;
  endsequence

  a_upper_write_word: assert property (@(posedge clk) disable iff (!rst_b)
    s_write_den1 |-> ##2 coefs_q.den1[15:8] == $past(reg_wdata, 2)) // RL1
    else $error("upper byte not in coefficient word");
  a_word_lower_join: assert property (@(posedge clk) disable iff (!rst_b)
    past_valid_q |-> coefs_q.num3 == $past({regs[8], regs[9]})) // RL1
    else $error("num3 word not joined from its bytes");
  a_full_span_kept: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr && reg_addr == AFCB_OFS_NUM0_UPPER && reg_wdata == 8'h80)
    ##1 (reg_wr && reg_addr == AFCB_OFS_NUM0_LOWER && reg_wdata == 8'h00)
    |-> ##2 coefs_q.num0 == -16'sd32768) // RL2
    else $error("most negative code not kept");
  a_write_readback: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr && in_map) ##1 (reg_rd && $stable(reg_addr) && !reg_wr)
    |-> ##1 reg_rdata_q == $past(reg_wdata, 2)) // RL3
    else $error("readback differs from written byte");
  a_den1_reset: assert property (@(posedge clk)
    !rst_b |-> ##1 (!rst_b || past_valid_q ||
      coefs_q.den1 == 16'h537E)) // RL4
    else $error("den1 reset value wrong");
  a_reset_values: assert property (@(posedge clk) disable iff (!rst_b)
    !past_valid_q |-> regs[2] == 8'h6B && regs[3] == 8'hE3) // RL5
    else $error("num0 reset value wrong");
  a_num1_reset: assert property (@(posedge clk) disable iff (!rst_b)
    !past_valid_q |-> regs[4] == 8'h96 && regs[5] == 8'h66) // RL6
    else $error("num1 reset value wrong");
  a_num2_upper_reset: assert property (@(posedge clk) disable iff (!rst_b)
    !past_valid_q |-> regs[6] == 8'h67) // RL7
    else $error("num2 upper reset value wrong");
  a_num3_upper_reset: assert property (@(posedge clk) disable iff (!rst_b)
    !past_valid_q |-> regs[8] == 8'h6B) // RL8
    else $error("num3 upper reset value wrong");
  a_read_no_effect: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd && !reg_wr) |=> $stable(coefs_q)
      || $past(reg_wr, 2)) // RL9
    else $error("read changed a coefficient");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd && !in_map) |=> reg_rdata_q == 8'h00) // RL9
    else $error("unmapped read not zero");

  // write into one mapped byte
  sequence s_wr_to(logic [7:0] ofs);
    reg_wr && in_map && reg_addr == ofs;
  endsequence

  // each byte reaches its half of the word two edges later
  a_den1_lower_write: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    s_wr_to(AFCB_OFS_DEN1_LOWER) |->
      ##2 coefs_q.den1[7:0] == $past(reg_wdata, 2))
    else $error("den1 lower byte not in its word");

  a_num0_upper_write: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    s_wr_to(AFCB_OFS_NUM0_UPPER) |->
      ##2 coefs_q.num0[15:8] == $past(reg_wdata, 2))
    else $error("num0 upper byte not in its word");

  a_num0_lower_write: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    s_wr_to(AFCB_OFS_NUM0_LOWER) |->
      ##2 coefs_q.num0[7:0] == $past(reg_wdata, 2))
    else $error("num0 lower byte not in its word");

  a_num1_upper_write: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    s_wr_to(AFCB_OFS_NUM1_UPPER) |->
      ##2 coefs_q.num1[15:8] == $past(reg_wdata, 2))
    else $error("num1 upper byte not in its word");

  a_num1_lower_write: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    s_wr_to(AFCB_OFS_NUM1_LOWER) |->
      ##2 coefs_q.num1[7:0] == $past(reg_wdata, 2))
    else $error("num1 lower byte not in its word");

  a_num2_upper_write: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    s_wr_to(AFCB_OFS_NUM2_UPPER) |->
      ##2 coefs_q.num2[15:8] == $past(reg_wdata, 2))
    else $error("num2 upper byte not in its word");

  a_num2_lower_write: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    s_wr_to(AFCB_OFS_NUM2_LOWER) |->
      ##2 coefs_q.num2[7:0] == $past(reg_wdata, 2))
    else $error("num2 lower byte not in its word");

  a_num3_upper_write: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    s_wr_to(AFCB_OFS_NUM3_UPPER) |->
      ##2 coefs_q.num3[15:8] == $past(reg_wdata, 2))
    else $error("num3 upper byte not in its word");

  a_num3_lower_write: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    s_wr_to(AFCB_OFS_NUM3_LOWER) |->
      ##2 coefs_q.num3[7:0] == $past(reg_wdata, 2))
    else $error("num3 lower byte not in its word");

  // words follow their byte pairs
  a_den1_join: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    past_valid_q |-> coefs_q.den1 == $past({regs[0], regs[1]}))
    else $error("den1 word not joined from its bytes");

  a_num0_join: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    past_valid_q |-> coefs_q.num0 == $past({regs[2], regs[3]}))
    else $error("num0 word not joined from its bytes");

  a_num1_join: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    past_valid_q |-> coefs_q.num1 == $past({regs[4], regs[5]}))
    else $error("num1 word not joined from its bytes");

  a_num2_join: assert property ( // RL1
    @(posedge clk) disable iff (!rst_b)
    past_valid_q |-> coefs_q.num2 == $past({regs[6], regs[7]}))
    else $error("num2 word not joined from its bytes");

  // most positive code survives the join
  a_max_code_kept: assert property ( // RL2
    @(posedge clk) disable iff (!rst_b)
    s_wr_to(AFCB_OFS_NUM1_UPPER) ##0 reg_wdata == 8'h7F
    ##1 s_wr_to(AFCB_OFS_NUM1_LOWER) ##0 reg_wdata == 8'hFF
    |-> ##2 coefs_q.num1 == 16'sh7FFF)
    else $error("most positive code not kept");

  // reset values of the remaining bytes
  a_den1_upper_reset: assert property ( // RL4
    @(posedge clk) disable iff (!rst_b)
    !past_valid_q |-> regs[0] == 8'h53)
    else $error("den1 upper reset value wrong");

  a_den1_lower_reset: assert property ( // RL4
    @(posedge clk) disable iff (!rst_b)
    !past_valid_q |-> regs[1] == 8'h7E)
    else $error("den1 lower reset value wrong");

  a_num2_lower_reset: assert property ( // RL7
    @(posedge clk) disable iff (!rst_b)
    !past_valid_q |-> regs[7] == 8'h00)
    else $error("num2 lower reset value wrong");

  a_num3_lower_reset: assert property ( // RL8
    @(posedge clk) disable iff (!rst_b)
    !past_valid_q |-> regs[9] == 8'h00)
    else $error("num3 lower reset value wrong");

  // read data only after a read strobe
  a_rdata_idle: assert property ( // RL9
    @(posedge clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata_q == 8'h00)
    else $error("read data outside its cycle");

  // bank changes only by a mapped write
  a_unmapped_write_ignored: assert property ( // RL3
    @(posedge clk) disable iff (!rst_b)
    (reg_wr && !in_map) |=> $stable(regs_flat))
    else $error("unmapped write changed the bank");

  a_idle_keeps_bank: assert property ( // RL9
    @(posedge clk) disable iff (!rst_b)
    !reg_wr |=> $stable(regs_flat))
    else $error("bank changed with no write");

  a_read_keeps_bank: assert property ( // RL9
    @(posedge clk) disable iff (!rst_b)
    reg_rd |=> $stable(regs_flat))
    else $error("read changed the bank");

  a_coefs_idle: assert property ( // RL9
    @(posedge clk) disable iff (!rst_b)
    (!reg_wr && !$past(reg_wr)) |=> $stable(coefs_q))
    else $error("coefficient changed with no write");
endmodule

// [rtl/afcb_pkg.sv]
// package: offsets, reset values and carrier types of the coefficient bank
// assumes: byte-wide register port with 8-bit addresses
package afcb_pkg;
  localparam int AFCB_NUM_REGS = 10;
  localparam int AFCB_NUM_COEFS = 5;
  localparam logic [7:0] AFCB_FIRST_OFFSET = 8'h19;
  localparam logic [7:0] AFCB_LAST_OFFSET = 8'h22;
  localparam logic [7:0] AFCB_OFS_DEN1_UPPER = 8'h19;
  localparam logic [7:0] AFCB_OFS_DEN1_LOWER = 8'h1A;
  localparam logic [7:0] AFCB_OFS_NUM0_UPPER = 8'h1B;
  localparam logic [7:0] AFCB_OFS_NUM0_LOWER = 8'h1C;
  localparam logic [7:0] AFCB_OFS_NUM1_UPPER = 8'h1D;
  localparam logic [7:0] AFCB_OFS_NUM1_LOWER = 8'h1E;
  localparam logic [7:0] AFCB_OFS_NUM2_UPPER = 8'h1F;
  localparam logic [7:0] AFCB_OFS_NUM2_LOWER = 8'h20;
  localparam logic [7:0] AFCB_OFS_NUM3_UPPER = 8'h21;
  localparam logic [7:0] AFCB_OFS_NUM3_LOWER = 8'h22;
  localparam logic [7:0] AFCB_RST_DEN1_UPPER = 8'h53;
  localparam logic [7:0] AFCB_RST_DEN1_LOWER = 8'h7E;
  localparam logic [7:0] AFCB_RST_NUM0_UPPER = 8'h6B;
  localparam logic [7:0] AFCB_RST_NUM0_LOWER = 8'hE3;
  localparam logic [7:0] AFCB_RST_NUM1_UPPER = 8'h96;
  localparam logic [7:0] AFCB_RST_NUM1_LOWER = 8'h66;
  localparam logic [7:0] AFCB_RST_NUM2_UPPER = 8'h67;
  localparam logic [7:0] AFCB_RST_NUM2_LOWER = 8'h00;
  localparam logic [7:0] AFCB_RST_NUM3_UPPER = 8'h6B;
  localparam logic [7:0] AFCB_RST_NUM3_LOWER = 8'h00;
  localparam logic [7:0] AFCB_UNMAPPED_DATA = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } afcb_req_s;

  typedef struct packed {
    logic signed [15:0] den1;
    logic signed [15:0] num0;
    logic signed [15:0] num1;
    logic signed [15:0] num2;
    logic signed [15:0] num3;
  } afcb_coefs_s;
endpackage

// [rtl/afcb_byte_reg.sv]
// file: one byte-wide read/write register with a reset value
// assumes: write enable decoded by the parent, same clock domain
`timescale 1ns/1ps
module afcb_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] value_q
);
  import afcb_pkg::*;

  // all eight bits writable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      value_q <= RESET_VALUE;
    end else if (wr_en) begin
      value_q <= wdata; // RL3
    end
  end
endmodule

// [bench/test_audio_filter_coefficient_bank.sv]
// file: self-checking bench for the coefficient bank, random and corner data
// assumes: afcb_pkg compiled first, bench drives the register port directly
`timescale 1ns/1ps
module test_audio_filter_coefficient_bank;
  import afcb_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_q;
  afcb_coefs_s coefs_q;
  logic [7:0] exp_q [AFCB_NUM_REGS];
  logic [7:0] rst_tab [AFCB_NUM_REGS] = '{AFCB_RST_DEN1_UPPER,
    AFCB_RST_DEN1_LOWER, AFCB_RST_NUM0_UPPER, AFCB_RST_NUM0_LOWER,
    AFCB_RST_NUM1_UPPER, AFCB_RST_NUM1_LOWER, AFCB_RST_NUM2_UPPER,
    AFCB_RST_NUM2_LOWER, AFCB_RST_NUM3_UPPER, AFCB_RST_NUM3_LOWER};
  logic [7:0] d;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 94;
  always #2.5 clk = ~clk;
  afcb_bank #(.NUM_REGS(AFCB_NUM_REGS)) i_dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .coefs_q(coefs_q));
  // expected signed word: upper byte joined to the following lower byte
  function automatic logic [15:0] word_of(int k);
    return {exp_q[2*k], exp_q[2*k+1]};
  endfunction
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] want, string what);
    cmp_count++;
    if (got !== want) begin
      mismatches++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  // hold keeps the strobe up for a back-to-back write
  task automatic wr(logic [7:0] a, logic [7:0] v, bit hold = 1'b0);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    if (!hold) begin
      reg_wr <= 1'b0;
    end
    if (a >= AFCB_FIRST_OFFSET && a <= AFCB_LAST_OFFSET) begin
      exp_q[int'(a - AFCB_FIRST_OFFSET)] = v;
    end
  endtask
  // read data stands only in the cycle after the strobe, then returns to 0
  task automatic rd(logic [7:0] a, logic [7:0] want);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata_q}, {8'h00, want}, "read data");
    @(posedge clk);
    #1 chk({8'h00, reg_rdata_q}, 16'h0000, "read idle");
  endtask
  task automatic check_all;
    for (int i = 0; i < AFCB_NUM_REGS; i++) begin
      rd(AFCB_FIRST_OFFSET + 8'(i), exp_q[i]);
    end
    for (int k = 0; k < AFCB_NUM_COEFS; k++) begin
      chk(coefs_q[79-16*k -: 16], word_of(k), "coefficient word");
    end
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    exp_q = rst_tab;
    @(posedge clk);
  endtask
  initial begin
    #50000;
    mismatches++;
    test_done();
  end
  initial begin
    do_reset();
    check_all();
    $display("test reset values done");
    // extremes -32768, 32767, then random codes, each written then read
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < AFCB_NUM_REGS; i++) begin
        d = (r == 0) ? (i[0] ? 8'h00 : 8'h80) :
            (r == 1) ? (i[0] ? 8'hFF : 8'h7F) : 8'($random(seed));
        wr(AFCB_FIRST_OFFSET + 8'(i), d);
        rd(AFCB_FIRST_OFFSET + 8'(i), d);
      end
      check_all();
    end
    // corner: extremes written back to back into one word each
    wr(AFCB_OFS_NUM0_UPPER, 8'h80, 1'b1);
    wr(AFCB_OFS_NUM0_LOWER, 8'h00, 1'b1);
    wr(AFCB_OFS_NUM1_UPPER, 8'h7F, 1'b1);
    wr(AFCB_OFS_NUM1_LOWER, 8'hFF);
    check_all();
    $display("test write and read back done");
    // writes outside the map leave the bank untouched, reads give 0x00
    foreach (rst_tab[j]) begin
      d = (j < 2) ? 8'h18 - 8'(j * 24) : 8'h23 + 8'({$random(seed)} % 8);
      wr(d, 8'($random(seed)));
      rd(d, AFCB_UNMAPPED_DATA);
    end
    check_all();
    $display("test unmapped access done");
    do_reset();
    check_all();
    $display("test second reset done");
    test_done();
  end
endmodule
